// File: hw/transmission_header_codec.sv
`timescale 1ns/1ps
// Behaviour
// [R1] golay code on count, indicator and header
// [R2] 7x24 interleaving goes with the coding
// [R3] one block of seven 24-bit codewords
// [R4] scramble before coding and interleaving
// [R5] packet mode bypasses coding, interleave, scramble
// [R6] topology subfield holds last id low bits
// [R7] topology subfield zero before any update
// [R8] queue type 00: subfield ignored
// [R9] queue type 01: reservation precedence and length
// [R10] queue type 10: link precedence, first subscriber
// [R11] queue type 11 invalid, header still delivered
// [R12] precedence 0 urgent, 1 priority, 2 else
// [R13] unknown received precedence treated as routine
// [R14] rows written, columns sent, receiver inverts
// [R15] extended golay, corrects three errors per word
module transmission_header_codec
  import transmission_header_codec_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  output logic [31:0]      prdata_o,
  output logic             pready_o,
  output logic             pslverr_o,
  output logic             tx_valid_o,
  output logic             tx_bit_o,
  input  wire logic        tx_ready_i,
  input  wire logic        rx_valid_i,
  input  wire logic        rx_first_i,
  input  wire logic        rx_bit_i
);

  typedef enum logic {TX_IDLE, TX_SEND} tx_state_type;
  typedef enum logic [1:0] {RX_COLLECT, RX_DECODE, RX_PARSE} rx_state_type;

  // software controls
  logic             pkt_q;       // packet mode interface
  logic             scr_q;       // scrambling enable
  logic [11:0]      wc_q;        // outgoing word count
  logic [11:0]      mi_q;        // outgoing message indicator
  tx_hdr_type       txh_q;       // outgoing header fields
  logic [2:0]       topo_q;      // low bits of last topology id
  // apb slave
  logic             ack_q;       // access phase answered next cycle
  logic [31:0]      prdata_q;
  logic             slverr_q;
  logic             acc;         // access phase, first cycle
  logic             wr_en;       // write commits here
  logic             mapped;
  logic [31:0]      rdata;
  // transmitter
  tx_state_type     tx_state_q;
  logic [BLK_W-1:0] tx_sh_q;     // serial bits, next one on top
  logic [7:0]       tx_cnt_q;    // bits still to go
  logic             start;
  raw_type          tx_raw;
  logic [RAW_W-1:0] tx_dat;
  logic [BLK_W-1:0] tx_rows;
  // receiver
  rx_state_type     rx_state_q;
  logic [BLK_W-1:0] rx_sh_q;     // received serial bits
  logic [7:0]       rx_cnt_q;
  logic [BLK_W-1:0] rx_rows;
  logic [2:0]       iss_q;       // next codeword to decode
  logic [2:0]       cap_q;       // next result to capture
  logic [RAW_W-1:0] rx_raw_q;    // corrected data bits
  raw_type          rx_dat;
  rx_hdr_type       rxh_q;
  logic [23:0]      rxc_q;       // received count and indicator
  logic [15:0]      errs_q;      // bits corrected in last header
  logic             done_q;      // header received, sticky
  logic             fail_q;      // uncorrectable codeword, sticky
  logic             tinv_q;      // queue type 11 seen, sticky
  logic             dec_valid;
  logic [11:0]      dec_data;
  logic [1:0]       dec_nerr;
  logic             dec_fail;
  logic [7:0]       rx_len;

  // one decoder shared by the seven codewords, one word per cycle
  golay_decoder u_dec (
    .core_clk_i  (core_clk_i),
    .rst_i       (rst_i),
    .in_valid_i  (rx_state_q == RX_DECODE && !pkt_q && iss_q < 3'(CW_NUM)),
    .in_word_i   (rx_rows[BLK_W-1-CW_W*int'(iss_q) -: CW_W]), // [R15]
    .out_valid_o (dec_valid),
    .out_data_o  (dec_data),
    .out_nerr_o  (dec_nerr),
    .out_fail_o  (dec_fail)
  );

  // apb decode; one wait state keeps read data registered
  assign acc    = psel_i && penable_i && !ack_q;
  assign wr_en  = psel_i && penable_i && ack_q && pwrite_i && !slverr_q;
  assign mapped = (paddr_i[1:0] == 2'h0) && (paddr_i <= REG_RX_ERR);
  assign start  = wr_en && paddr_i == REG_CTRL && pwdata_i[CTRL_START];

  // read mux, reserved bits read zero
  always_comb begin
    rdata = 32'h0000_0000;
    unique case (paddr_i)
      REG_CTRL: begin
        rdata[CTRL_PKT] = pkt_q;
        rdata[CTRL_SCR] = scr_q;
      end
      REG_STATUS: begin
        rdata[STAT_BUSY] = tx_state_q == TX_SEND;
        rdata[STAT_DONE] = done_q;
        rdata[STAT_FAIL] = fail_q;
        rdata[STAT_TINV] = tinv_q;
      end
      REG_TX_COUNT: rdata = 32'({mi_q, wc_q});
      REG_TX_HDR:   rdata = 32'(txh_q);
      REG_TOPO:     rdata = 32'(topo_q);
      REG_RX_COUNT: rdata = 32'(rxc_q);
      REG_RX_HDR:   rdata = 32'(rxh_q);
      REG_RX_ERR:   rdata = 32'(errs_q);
      default:      rdata = 32'h0000_0000;
    endcase
  end

  // apb answer: ready in the second access cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      ack_q    <= 1'b0;
      prdata_q <= 32'h0000_0000;
      slverr_q <= 1'b0;
    end else begin
      ack_q <= acc;
      if (acc) begin
        prdata_q <= mapped ? rdata : 32'h0000_0000;
        slverr_q <= !mapped;
      end
    end
  end

  assign prdata_o  = prdata_q;
  assign pready_o  = ack_q;
  assign pslverr_o = ack_q && slverr_q;

  // software writable registers
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      pkt_q  <= 1'b0;
      scr_q  <= 1'b0;
      wc_q   <= 12'h000;
      mi_q   <= 12'h000;
      txh_q  <= '0;
      topo_q <= 3'h0; // [R7]
    end else if (wr_en) begin
      unique case (paddr_i)
        REG_CTRL: begin
          pkt_q <= pwdata_i[CTRL_PKT];
          scr_q <= pwdata_i[CTRL_SCR];
        end
        REG_TX_COUNT: {mi_q, wc_q} <= pwdata_i[23:0];
        REG_TX_HDR:   txh_q <= tx_hdr_type'(pwdata_i[$bits(tx_hdr_type)-1:0]);
        // software writes the full id of each topology update it sends
        REG_TOPO:     topo_q <= pwdata_i[TOPO_W-1:0]; // [R6]
        default: ;
      endcase
    end
  end

  // assemble outgoing data bits
  always_comb begin
    tx_raw                         = '0;
    tx_raw.word_count_field        = wc_q;
    tx_raw.message_indicator_field = mi_q;
    tx_raw.sel                     = txh_q.sel;
    tx_raw.topo                    = topo_q; // [R6] [R7]
    tx_raw.qt                      = txh_q.qt;
    unique case (txh_q.qt)
      QT_RES: tx_raw.sub = {txh_q.qprec, txh_q.qlen}; // [R9]
      QT_DAP: begin
        // urgent beats priority beats routine
        if (txh_q.urg) tx_raw.sub = {PREC_URGENT, txh_q.fsub}; // [R12]
        else if (txh_q.pri) tx_raw.sub = {PREC_PRIORITY, txh_q.fsub}; // [R12]
        else tx_raw.sub = {PREC_ROUTINE, txh_q.fsub}; // [R12] [R10]
      end
      default: tx_raw.sub = 9'h000; // [R8]
    endcase
    // scrambling comes first so coding protects the scrambled bits
    tx_dat = (scr_q && !pkt_q) ? scramble(tx_raw) : tx_raw; // [R4] [R5]
    for (int r = 0; r < CW_NUM; r++) begin
      tx_rows[BLK_W-1-CW_W*r -: CW_W] =
        golay_encode(tx_dat[RAW_W-1-DATA_W*r -: DATA_W]); // [R1] [R3] [R15]
    end
  end

  // transmit shifter; a start while busy is dropped
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      tx_state_q <= TX_IDLE;
      tx_sh_q    <= '0;
      tx_cnt_q   <= 8'h00;
    end else begin
      unique case (tx_state_q)
        TX_IDLE: begin
          if (start) begin
            tx_state_q <= TX_SEND;
            if (pkt_q) begin
              tx_sh_q  <= {tx_raw, {(BLK_W-RAW_W){1'b0}}}; // [R5]
              tx_cnt_q <= LEN_PKT;
            end else begin
              tx_sh_q  <= interleave(tx_rows); // [R2] [R14]
              tx_cnt_q <= LEN_CODED;
            end
          end
        end
        TX_SEND: begin
          if (tx_ready_i) begin
            tx_sh_q  <= {tx_sh_q[BLK_W-2:0], 1'b0};
            tx_cnt_q <= tx_cnt_q - 8'h01;
            if (tx_cnt_q == 8'h01) tx_state_q <= TX_IDLE;
          end
        end
      endcase
    end
  end

  assign tx_valid_o = tx_state_q == TX_SEND;
  assign tx_bit_o   = tx_sh_q[BLK_W-1];

  // receive side
  assign rx_len  = pkt_q ? LEN_PKT : LEN_CODED;
  assign rx_rows = deinterleave(rx_sh_q); // [R14] [R2]
  assign rx_dat  = (scr_q && !pkt_q) ? scramble(rx_raw_q) : rx_raw_q; // [R4] [R5]

  // collect, decode word by word, then parse
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rx_state_q <= RX_COLLECT;
      rx_sh_q    <= '0;
      rx_cnt_q   <= 8'h00;
      iss_q      <= 3'h0;
      cap_q      <= 3'h0;
      rx_raw_q   <= '0;
      errs_q     <= 16'h0000;
    end else begin
      unique case (rx_state_q)
        RX_COLLECT: begin
          if (rx_valid_i) begin
            rx_sh_q  <= {rx_sh_q[BLK_W-2:0], rx_bit_i};
            rx_cnt_q <= rx_first_i ? 8'h01 : rx_cnt_q + 8'h01;
            if ((rx_first_i ? 8'h01 : rx_cnt_q + 8'h01) == rx_len) begin
              rx_state_q <= RX_DECODE;
              iss_q      <= 3'h0;
              cap_q      <= 3'h0;
              errs_q     <= 16'h0000;
            end
          end
        end
        RX_DECODE: begin
          if (pkt_q) begin
            rx_raw_q   <= rx_sh_q[RAW_W-1:0]; // [R5]
            rx_state_q <= RX_PARSE;
          end else begin
            if (iss_q < 3'(CW_NUM)) iss_q <= iss_q + 3'h1;
            if (dec_valid) begin
              rx_raw_q[RAW_W-1-DATA_W*int'(cap_q) -: DATA_W] <= dec_data; // [R1] [R3]
              errs_q <= errs_q + 16'(dec_nerr);
              cap_q  <= cap_q + 3'h1;
              if (cap_q == 3'(CW_NUM-1)) rx_state_q <= RX_PARSE;
            end
          end
        end
        RX_PARSE: begin
          rx_cnt_q   <= 8'h00;
          rx_state_q <= RX_COLLECT;
        end
        default: rx_state_q <= RX_COLLECT;
      endcase
    end
  end

  // field parse; ignored subfields read back as zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      rxh_q <= '0;
      rxc_q <= 24'h000000;
    end else if (rx_state_q == RX_PARSE) begin
      rxc_q      <= {rx_dat.message_indicator_field, rx_dat.word_count_field};
      rxh_q      <= '0;
      rxh_q.sel  <= rx_dat.sel;
      rxh_q.topo <= rx_dat.topo;
      rxh_q.qt   <= rx_dat.qt;
      unique case (rx_dat.qt)
        QT_RES: begin
          rxh_q.res_ok <= 1'b1; // [R9]
          {rxh_q.qprec, rxh_q.qlen} <= rx_dat.sub; // [R9]
        end
        QT_DAP: begin
          rxh_q.dap_ok <= 1'b1; // [R10]
          rxh_q.fsub   <= rx_dat.sub[6:0]; // [R10]
          // codes above routine fall back to routine
          rxh_q.lprec  <= (rx_dat.sub[8:7] > PREC_ROUTINE) ?
                          PREC_ROUTINE : rx_dat.sub[8:7]; // [R13]
        end
        default: ; // [R8] [R11]
      endcase
    end
  end

  // sticky status; a new event in the clearing cycle wins
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      done_q <= 1'b0;
      fail_q <= 1'b0;
      tinv_q <= 1'b0;
    end else begin
      if (wr_en && paddr_i == REG_STATUS) begin
        if (pwdata_i[STAT_DONE]) done_q <= 1'b0;
        if (pwdata_i[STAT_FAIL]) fail_q <= 1'b0;
        if (pwdata_i[STAT_TINV]) tinv_q <= 1'b0;
      end
      // header still delivered so following frames go on normally
      if (rx_state_q == RX_PARSE) done_q <= 1'b1; // [R11]
      if (rx_state_q == RX_PARSE && rx_dat.qt == QT_BAD) tinv_q <= 1'b1; // [R11]
      if (rx_state_q == RX_DECODE && dec_valid && dec_fail) fail_q <= 1'b1; // [R15]
    end
  end

endmodule

// File: common/transmission_header_codec_pkg.sv
package transmission_header_codec_pkg;

  // block geometry: seven (24,12) codewords per interleaving block
  localparam int CW_NUM = 7;
  localparam int CW_W   = 24;
  localparam int DATA_W = 12;
  localparam int BLK_W  = CW_NUM * CW_W;
  localparam int RAW_W  = CW_NUM * DATA_W;

  // serial lengths of one header, coded and packet mode
  localparam logic [7:0] LEN_CODED = 8'(BLK_W);
  localparam logic [7:0] LEN_PKT   = 8'(RAW_W);

  // apb register byte offsets
  localparam logic [7:0] REG_CTRL     = 8'h00;
  localparam logic [7:0] REG_STATUS   = 8'h04;
  localparam logic [7:0] REG_TX_COUNT = 8'h08;
  localparam logic [7:0] REG_TX_HDR   = 8'h0C;
  localparam logic [7:0] REG_TOPO     = 8'h10;
  localparam logic [7:0] REG_RX_COUNT = 8'h14;
  localparam logic [7:0] REG_RX_HDR   = 8'h18;
  localparam logic [7:0] REG_RX_ERR   = 8'h1C;

  // control and status bit positions
  localparam int CTRL_PKT    = 0;
  localparam int CTRL_SCR    = 1;
  localparam int CTRL_START  = 8;
  localparam int STAT_BUSY   = 0;
  localparam int STAT_DONE   = 1;
  localparam int STAT_FAIL   = 2;
  localparam int STAT_TINV   = 3;
  localparam int TOPO_W      = 3;

  // queue type codes
  localparam logic [1:0] QT_NONE = 2'h0;
  localparam logic [1:0] QT_RES  = 2'h1;
  localparam logic [1:0] QT_DAP  = 2'h2;
  localparam logic [1:0] QT_BAD  = 2'h3;

  // link precedence codes
  localparam logic [1:0] PREC_URGENT   = 2'h0;
  localparam logic [1:0] PREC_PRIORITY = 2'h1;
  localparam logic [1:0] PREC_ROUTINE  = 2'h2;

  // additive scrambler x^7 + x^4 + 1
  localparam logic [6:0] SCR_SEED  = 7'h7F;
  localparam int         SCR_TAP_A = 6;
  localparam int         SCR_TAP_B = 3;

  // software view of the transmit header register
  typedef struct packed {
    logic [6:0] fsub;   // first subscriber number
    logic [5:0] qlen;   // queue length
    logic [2:0] qprec;  // queue precedence
    logic       pri;    // priority traffic in frame
    logic       urg;    // urgent traffic in frame
    logic [1:0] qt;     // queue type bits
    logic [3:0] sel;    // selection bits
  } tx_hdr_type;

  // software view of the received header register
  typedef struct packed {
    logic [6:0] fsub;
    logic [1:0] lprec;
    logic [5:0] qlen;
    logic [2:0] qprec;
    logic       dap_ok;
    logic       res_ok;
    logic [1:0] qt;
    logic [2:0] topo;
    logic [3:0] sel;
  } rx_hdr_type;

  // 84 data bits carried by one block, first bit on top
  typedef struct packed {
    logic [11:0] word_count_field;
    logic [11:0] message_indicator_field;
    logic [3:0]  sel;
    logic [2:0]  topo;
    logic [1:0]  qt;
    logic [8:0]  sub;
    logic [41:0] rsv;
  } raw_type;

  // parity matrix of the extended code, row 0 on top
  localparam logic [143:0] GOLAY_B = {
    12'hDC5, 12'hB8B, 12'h717, 12'hE2D, 12'hC5B, 12'h8B7,
    12'h16F, 12'h2DD, 12'h5B9, 12'hB71, 12'h6E3, 12'hFFE};

  function automatic logic [11:0] b_row(input int i);
    return GOLAY_B[143-12*i -: 12];
  endfunction

  // row vector times matrix, element i is bit 11-i
  function automatic logic [11:0] mul_b(input logic [11:0] v);
    logic [11:0] r;
    r = 12'h000;
    for (int i = 0; i < DATA_W; i++) begin
      if (v[DATA_W-1-i]) r = r ^ b_row(i);
    end
    return r;
  endfunction

  function automatic logic [3:0] weight12(input logic [11:0] v);
    logic [3:0] w;
    w = 4'h0;
    for (int i = 0; i < DATA_W; i++) w = w + 4'(v[i]);
    return w;
  endfunction

  function automatic logic [23:0] golay_encode(input logic [11:0] d);
    return {d, mul_b(d)};
  endfunction

  // same function scrambles and descrambles
  function automatic logic [RAW_W-1:0] scramble(input logic [RAW_W-1:0] v);
    logic [RAW_W-1:0] o;
    logic [6:0]       s;
    s = SCR_SEED;
    for (int k = RAW_W-1; k >= 0; k--) begin
      o[k] = v[k] ^ s[SCR_TAP_A];
      s = {s[5:0], s[SCR_TAP_A] ^ s[SCR_TAP_B]};
    end
    return o;
  endfunction

  // rows written in, columns sent out, column 0 is the codeword msb
  function automatic logic [BLK_W-1:0] interleave(input logic [BLK_W-1:0] rows);
    logic [BLK_W-1:0] ser;
    ser = '0;
    for (int r = 0; r < CW_NUM; r++) begin
      for (int c = 0; c < CW_W; c++) begin
        ser[BLK_W-1-(c*CW_NUM+r)] = rows[BLK_W-1-CW_W*r-c];
      end
    end
    return ser;
  endfunction

  function automatic logic [BLK_W-1:0] deinterleave(input logic [BLK_W-1:0] ser);
    logic [BLK_W-1:0] rows;
    rows = '0;
    for (int r = 0; r < CW_NUM; r++) begin
      for (int c = 0; c < CW_W; c++) begin
        rows[BLK_W-1-CW_W*r-c] = ser[BLK_W-1-(c*CW_NUM+r)];
      end
    end
    return rows;
  endfunction

endpackage

// File: hw/golay_decoder.sv
`timescale 1ns/1ps
module golay_decoder
  import transmission_header_codec_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        in_valid_i,
  input  wire logic [23:0] in_word_i,
  output logic             out_valid_o,
  output logic [11:0]      out_data_o,
  output logic [1:0]       out_nerr_o,
  output logic             out_fail_o
);

  logic [11:0] u, v, s, sb;  // data half, parity half, syndromes
  logic [11:0] e1, e2;       // error patterns per half
  logic        found;        // a pattern of weight three or less matched
  logic [3:0]  wsum;         // corrected bit count
  logic        valid_q;
  logic [11:0] data_q;
  logic [1:0]  nerr_q;
  logic        fail_q;

  // syndrome search, corrects up to three errors per word
  always_comb begin
    u     = in_word_i[23:12];
    v     = in_word_i[11:0];
    s     = mul_b(u) ^ v; // [R15]
    sb    = mul_b(s);
    e1    = 12'h000;
    e2    = 12'h000;
    found = 1'b0;
    // all errors in parity half
    if (weight12(s) <= 4'h3) begin
      e2    = s;
      found = 1'b1;
    end
    // one data error plus up to two parity errors
    for (int i = 0; i < DATA_W; i++) begin
      if (!found && weight12(s ^ b_row(i)) <= 4'h2) begin
        e1    = 12'(12'h800 >> i);
        e2    = s ^ b_row(i);
        found = 1'b1;
      end
    end
    // all errors in data half
    if (!found && weight12(sb) <= 4'h3) begin
      e1    = sb;
      found = 1'b1;
    end
    // one parity error plus up to two data errors
    for (int i = 0; i < DATA_W; i++) begin
      if (!found && weight12(sb ^ b_row(i)) <= 4'h2) begin
        e1    = sb ^ b_row(i);
        e2    = 12'(12'h800 >> i);
        found = 1'b1;
      end
    end
    wsum = weight12(e1) + weight12(e2);
  end

  // registered result, one cycle after the word goes in
  always_ff @(posedge core_clk_i) begin
    if (rst_i) begin
      valid_q <= 1'b0;
      data_q  <= 12'h000;
      nerr_q  <= 2'h0;
      fail_q  <= 1'b0;
    end else begin
      valid_q <= in_valid_i;
      if (in_valid_i) begin
        data_q <= u ^ e1;
        nerr_q <= wsum[1:0];
        fail_q <= !found;
      end
    end
  end

  assign out_valid_o = valid_q;
  assign out_data_o  = data_q;
  assign out_nerr_o  = nerr_q;
  assign out_fail_o  = fail_q;

endmodule

// File: tb/codec_assertions.sv
`timescale 1ns/1ps
module codec_checker
  import transmission_header_codec_pkg::*;
(
  input  wire logic        core_clk_i,
  input  wire logic        rst_i,
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic        pwrite_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] pwdata_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  input  wire logic        tx_valid_o,
  input  wire logic        tx_bit_o,
  input  wire logic        tx_ready_i
);
  logic [7:0] sent_q;  // bits accepted in the current header
  default clocking @(posedge core_clk_i); endclocking
  default disable iff (rst_i);
  // cleared between headers so each one counts from zero
  always_ff @(posedge core_clk_i) begin
    if (rst_i || !tx_valid_o) sent_q <= 8'h00;
    else if (tx_ready_i) sent_q <= sent_q + 8'h01;
  end
  apb_wait_a: assert property (psel_i && penable_i && !pready_o |=> pready_o)
    else $error("apb answer late");
  ready_pulse_a: assert property (pready_o |=> !pready_o)
    else $error("pready longer than one cycle");
  err_data_a: assert property (pslverr_o |-> pready_o && (pwrite_i || prdata_o == 32'h0))
    else $error("refused access not clean");
  bad_addr_a: assert property (psel_i && pready_o && paddr_i > REG_RX_ERR |-> pslverr_o)
    else $error("unmapped address accepted");
  bit_hold_a: assert property (tx_valid_o && !tx_ready_i |=> tx_valid_o && $stable(tx_bit_o))
    else $error("serial bit changed while stalled");
  start_tx_a: assert property (pready_o && pwrite_i && !pslverr_o && paddr_i == REG_CTRL
    && pwdata_i[CTRL_START] && !tx_valid_o |=> tx_valid_o)
    else $error("start did not open a header");
  tx_cause_a: assert property ($rose(tx_valid_o) |-> $past(pready_o) && $past(pwrite_i))
    else $error("header began without a start");
  tx_len_a: assert property (
    $fell(tx_valid_o) |-> sent_q == LEN_CODED || sent_q == LEN_PKT)
    else $error("header length wrong");
endmodule
bind transmission_header_codec codec_checker checker_inst (.core_clk_i(core_clk_i),
  .rst_i(rst_i), .psel_i(psel_i), .penable_i(penable_i), .pwrite_i(pwrite_i),
  .paddr_i(paddr_i), .pwdata_i(pwdata_i), .prdata_o(prdata_o), .pready_o(pready_o),
  .pslverr_o(pslverr_o), .tx_valid_o(tx_valid_o), .tx_bit_o(tx_bit_o),
  .tx_ready_i(tx_ready_i));

// File: tb/phy_model.sv
`timescale 1ns/1ps
module phy_model (
  input  wire logic         core_clk_i,
  input  wire logic         rst_i,
  input  wire logic         slow_i,
  input  wire logic         play_i,
  input  wire logic [0:167] flip_i,
  input  wire logic         tx_valid_i,
  input  wire logic         tx_bit_i,
  output logic              tx_ready_o,
  output logic              rx_valid_o,
  output logic              rx_first_o,
  output logic              rx_bit_o
);
  logic [0:167] cap_q;  // accepted bits, first at index 0
  logic [7:0]   n_q;    // accepted count
  logic [7:0]   i_q;    // replay position
  logic         run_q;  // replay under way
  // slow mode stalls the sender every other cycle
  always_ff @(posedge core_clk_i) begin
    if (rst_i) tx_ready_o <= 1'b0;
    else tx_ready_o <= slow_i ? !tx_ready_o : 1'b1;
  end
  // capture, then echo back with chosen bits inverted as channel errors
  always_ff @(posedge core_clk_i) begin
    rx_first_o <= 1'b0;
    if (rst_i) begin
      n_q <= 8'h00;
      i_q <= 8'h00;
      run_q <= 1'b0;
      rx_valid_o <= 1'b0;
      rx_bit_o <= 1'b0;
    end else if (run_q) begin
      rx_valid_o <= 1'b1;
      rx_first_o <= (i_q == 8'h00);
      rx_bit_o <= cap_q[i_q] ^ flip_i[i_q];
      i_q <= i_q + 8'h01;
      run_q <= (i_q + 8'h01 != n_q);
      if (i_q + 8'h01 == n_q) n_q <= 8'h00;
    end else begin
      rx_valid_o <= 1'b0;
      rx_bit_o <= !rx_bit_o;  // idle line toggles every cycle instead of holding the last bit
      i_q <= 8'h00;
      run_q <= play_i;
      if (tx_valid_i && tx_ready_o) begin
        cap_q[n_q] <= tx_bit_i;
        n_q <= n_q + 8'h01;
      end
    end
  end
endmodule

// File: tb/test_transmission_header_codec.sv
`timescale 1ns/1ps
module test_transmission_header_codec;
  import transmission_header_codec_pkg::*;
  logic core_clk_i, rst_i, psel, penable, pwrite, pready, pslverr, slow, play;
  logic tx_valid, tx_bit, tx_ready, rx_valid, rx_first, rx_bit, e;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata, d;
  logic [0:167] flip;
  logic [2:0]   topo;   // low bits of last topology id written
  int error_cnt, checks_done, cyc;
  transmission_header_codec DUT (.core_clk_i(core_clk_i), .rst_i(rst_i), .psel_i(psel),
    .penable_i(penable), .pwrite_i(pwrite), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(pready), .pslverr_o(pslverr), .tx_valid_o(tx_valid),
    .tx_bit_o(tx_bit), .tx_ready_i(tx_ready), .rx_valid_i(rx_valid),
    .rx_first_i(rx_first), .rx_bit_i(rx_bit));
  phy_model phy (.core_clk_i(core_clk_i), .rst_i(rst_i), .slow_i(slow), .play_i(play),
    .flip_i(flip), .tx_valid_i(tx_valid), .tx_bit_i(tx_bit), .tx_ready_o(tx_ready),
    .rx_valid_o(rx_valid), .rx_first_o(rx_first), .rx_bit_o(rx_bit));
  initial begin
    core_clk_i = 1'b0;
    forever #2 core_clk_i = !core_clk_i;
  end
  // hang guard, far above the expected run length
  always @(posedge core_clk_i) begin
    cyc++;
    if (cyc == 20000) begin
      error_cnt++;
      close_out();
    end
  end
  task automatic close_out;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic chk_s(input string what, input logic [0:167] exp, input logic [0:167] got);
    checks_done++;
    if (got !== exp) begin
      error_cnt++;
      $display("Error %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one apb transfer, held until pready is sampled high
  task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    @(posedge core_clk_i);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge core_clk_i);
    penable <= 1'b1;
    do @(posedge core_clk_i); while (pready !== 1'b1);
    d = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // own model of scrambler, code and column order
  function automatic logic [0:167] stream(input logic [83:0] raw, input logic pkt, scr);
    logic [83:0] v;
    logic [6:0]  s;
    logic [23:0] w [7];
    logic [0:167] o;
    v = raw;
    s = SCR_SEED;
    if (pkt) return {raw, 84'h0};
    for (int k = 83; k >= 0; k--) begin
      v[k] = raw[k] ^ (scr & s[6]);
      s = {s[5:0], s[6] ^ s[3]};
    end
    for (int r = 0; r < 7; r++) begin
      w[r] = {v[83-12*r -: 12], 12'h000};
      for (int i = 0; i < 12; i++) if (w[r][23-i]) w[r][11:0] ^= GOLAY_B[143-12*i -: 12];
    end
    for (int k = 0; k < 168; k++) o[k] = w[k%7][23-k/7];
    return o;
  endfunction
  // send one header, echo it back, check both directions
  task automatic run(input logic pkt, scr, input logic [1:0] qt, input logic u, p,
                     input logic [0:167] fl, input logic [31:0] xerr, input logic [1:0] xlp);
    logic [8:0] sub;
    rx_hdr_type h;
    logic [0:167] xs, gs;  // expected and captured stream
    sub = qt == QT_RES ? 9'h16B : qt == QT_DAP ? {u ? 2'h0 : p ? 2'h1 : 2'h2, 7'h4E} : 9'h0;
    xfer(1'b1, REG_TX_COUNT, 32'h003C_1A5C);
    xfer(1'b1, REG_TX_HDR, 32'(tx_hdr_type'{7'h4E, 6'h2B, 3'h5, p, u, qt, 4'h9}));
    // mode must already stand when the start write samples it
    xfer(1'b1, REG_CTRL, {30'h0, scr, pkt});
    xfer(1'b1, REG_CTRL, {23'h0, 1'b1, 6'h0, scr, pkt});
    @(posedge core_clk_i);
    while (tx_valid !== 1'b0) @(posedge core_clk_i);
    // word count leads the vector, message indicator follows
    xs = stream({24'hA5C3C1, 4'h9, topo, qt, sub, 42'h0}, pkt, scr);
    gs = pkt ? {phy.cap_q[0:83], 84'h0} : phy.cap_q;
    chk_s("stream", xs, gs);
    flip <= fl;
    play <= 1'b1;
    @(posedge core_clk_i);
    play <= 1'b0;
    do xfer(1'b0, REG_STATUS, 32'h0); while (d[STAT_DONE] !== 1'b1);
    chk("status", {28'h0, qt == QT_BAD, 3'h2}, d);
    xfer(1'b0, REG_RX_COUNT, 32'h0);
    chk("rx count", 32'h003C_1A5C, d);
    h = '0;
    h.sel = 4'h9;
    h.topo = topo;
    h.qt = qt;
    if (qt == QT_RES) {h.res_ok, h.qprec, h.qlen} = {1'b1, 3'h5, 6'h2B};
    if (qt == QT_DAP) {h.dap_ok, h.lprec, h.fsub} = {1'b1, xlp, 7'h4E};
    xfer(1'b0, REG_RX_HDR, 32'h0);
    chk("rx header", 32'(h), d);
    xfer(1'b0, REG_RX_ERR, 32'h0);
    chk("corrected", xerr, d);
    xfer(1'b1, REG_STATUS, 32'h0000_000E);
  endtask
  initial begin
    {rst_i, psel, penable, pwrite, paddr, pwdata, slow, play, flip, topo} = '0;
    rst_i = 1'b1;
    repeat (4) @(posedge core_clk_i);
    rst_i <= 1'b0;
    xfer(1'b0, REG_TOPO, 32'h0);
    chk("topo reset", 32'h0, d);
    xfer(1'b0, 8'h20, 32'h0);
    chk("unmapped", 32'h0000_0001, {d[30:0], e});
    run(1'b0, 1'b0, QT_DAP, 1'b0, 1'b0, '0, 32'h0, 2'h2);
    xfer(1'b1, REG_TOPO, 32'h0000_002D);
    topo = 3'h5;
    xfer(1'b0, REG_TOPO, 32'h0);
    chk("topo", 32'h0000_0005, d);
    slow <= 1'b1;
    run(1'b0, 1'b1, QT_RES, 1'b0, 1'b0, {3{1'b1, 6'h0}}, 32'h3, 2'h0);
    slow <= 1'b0;
    for (int q = 0; q < 4; q++) run(1'b1, 1'b1, q[1:0], 1'b0, 1'b0, '0, 32'h0, 2'h2);
    for (int k = 1; k < 4; k++) run(1'b0, 1'b0, QT_DAP, k[0], k[1], '0, 32'h0,
      k[0] ? 2'h0 : 2'h1);
    run(1'b1, 1'b0, QT_DAP, 1'b0, 1'b0, {34'h0, 1'b1, 133'h0}, 32'h0, 2'h2);
    close_out();
  end
endmodule
